// >>> core/pcs_core.sv
// Purpose: program counter, paging, reset vector, return stack and oscillator trim
// Assumes: op and operand are valid at the edge where cycle_tick is high
// Notes:   registers reached over AXI4-Lite; one write and one read at a time
`timescale 1ns/1ps
`include "pcs_map.svh"

// Behaviour
// RULE1: trim holds seven bits, bit0 reads zero
// RULE2: trim 0111111 gives the highest frequency
// RULE3: counter advances by one each cycle
// RULE4: jump loads counter bits 8:0 from operand
// RULE5: low counter register is counter bits 7:0; the PC register reads all ten counter bits 9:0
// RULE6: page select supplies bit 9 on loads
// RULE7: call and low writes clear bit 8
// RULE8: software keeps call targets in first half
// RULE9: reset points counter at last location
// RULE10: counter wraps from top to zero
// RULE11: reset clears the page select
// RULE12: return stack is two by twelve bits
// RULE13: call shifts level1 down, pushes counter+1
// RULE14: only the two newest returns survive
// RULE15: return pops level1, level2 is kept
// RULE16: return loads accumulator with its literal
// RULE17: no overflow or underflow flag exists
// RULE18: top-of-memory literal load fills the accumulator
// RULE19: counter is ten bits wide
module pcs_core
   import pcs_pkg::*;
#(
   parameter int CYCLE_DIV = `PCS_CYCLE_DIV
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [7:0]  araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // instruction stream
   output logic             cycle_tick,
   input  pcs_op_type       op,
   input  wire logic [8:0]  operand,
   // core state
   output logic [9:0]       instr_pointer,
   output logic [7:0]       acc,
   output logic             page_select_bit,
   output logic [6:0]       osc_trim_code,
   output logic [6:0]       osc_speed
);

   if (CYCLE_DIV < 1 || CYCLE_DIV > 256)
   begin : g_chk
      $error("pcs_core: CYCLE_DIV out of range");
   end

   pcs_stack_if #(.WIDTH(12)) stk ();

   pcs_stack #(.WIDTH(12)) u_stack (
      .aclk    (aclk),
      .aresetn (aresetn),
      .stk     (stk.store)
   );

   ////////////////////////////////////////////////////////////////////////
   // instruction-cycle enable
   logic [7:0] div_cnt;
   logic [7:0] next_div_cnt;

   always_comb
   begin
      cycle_tick   = (div_cnt == 8'(CYCLE_DIV - 1));
      next_div_cnt = cycle_tick ? 8'h00 : 8'(div_cnt + 8'h01);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div_cnt <= 8'h00;
      else
         div_cnt <= next_div_cnt;
   end

   ////////////////////////////////////////////////////////////////////////
   // counter, accumulator and stack strobes
   logic [9:0] next_pc;
   logic [7:0] next_acc;
   logic [9:0] pc_inc;

   always_comb
   begin
      pc_inc        = 10'(instr_pointer + 10'h001);   // RULE10
      next_pc       = instr_pointer;
      next_acc      = acc;
      stk.push      = 1'b0;
      stk.pop       = 1'b0;
      stk.push_data = {2'h0, pc_inc};
      if (cycle_tick)
      begin
         case (op)
            PCS_OP_SEQ:
               next_pc = pc_inc;                     // RULE3
            PCS_OP_LOAD_LIT:
            begin
               next_pc  = pc_inc;
               next_acc = operand[7:0];              // RULE18
            end
            PCS_OP_JUMP:
               next_pc = {page_select_bit, operand}; // RULE4 RULE6 RULE19
            PCS_OP_CALL:
            begin
               next_pc  = {page_select_bit, 1'b0, operand[7:0]}; // RULE7
               stk.push = 1'b1;                      // RULE13
            end
            PCS_OP_RET:
            begin
               next_pc  = stk.top[9:0];              // RULE15
               next_acc = operand[7:0];              // RULE16
               stk.pop  = 1'b1;
            end
            PCS_OP_PCL_WRITE:
               next_pc = {page_select_bit, 1'b0, operand[7:0]}; // RULE5 RULE7
            default:
               next_pc = pc_inc;
         endcase
      end
   end

   // accumulator has no documented reset, zero keeps simulation clean
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         instr_pointer <= `PCS_PC_RESET;             // RULE9
         acc           <= 8'h00;
      end
      else
      begin
         instr_pointer <= next_pc;
         acc           <= next_acc;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register file and bus slave
   logic [7:0]  trim;
   logic        aw_held;
   logic [7:0]  aw_addr_q;
   logic        w_held;
   logic [7:0]  w_data_q;
   logic        w_strb_q;
   logic        rd_trim;
   logic [7:0]  next_trim;
   logic        next_page;
   logic        next_aw_held;
   logic [7:0]  next_aw_addr;
   logic        next_w_held;
   logic [7:0]  next_w_data;
   logic        next_w_strb;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;
   logic        next_rd_trim;

   assign awready         = !aw_held && !bvalid;
   assign wready          = !w_held && !bvalid;
   assign arready         = !rvalid;
   assign osc_trim_code   = trim[7:1];               // RULE1
   // offset binary: 0111111 maps to all ones, the fastest setting
   assign osc_speed       = {~trim[7], trim[6:1]};   // RULE2

   always_comb
   begin
      next_trim    = trim;
      next_page    = page_select_bit;
      next_aw_held = aw_held;
      next_aw_addr = aw_addr_q;
      next_w_held  = w_held;
      next_w_data  = w_data_q;
      next_w_strb  = w_strb_q;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      next_rd_trim = rd_trim;
      if (awvalid && awready)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && wready)
      begin
         next_w_held = 1'b1;
         next_w_data = wdata[7:0];
         next_w_strb = wstrb[0];
      end
      if (bvalid && bready)
         next_bvalid = 1'b0;
      // write lands one cycle after both halves are held
      if (aw_held && w_held)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = `PCS_RESP_OKAY;
         case (aw_addr_q)
            `PCS_OFS_TRIM:
               if (w_strb_q)
                  next_trim = w_data_q & `PCS_TRIM_MASK; // RULE1
            `PCS_OFS_STATUS:
               if (w_strb_q)
                  next_page = w_data_q[`PCS_PAGE_POS];   // RULE6
            `PCS_OFS_PC, `PCS_OFS_ACC:
               next_bresp = `PCS_RESP_OKAY;
            default:
               next_bresp = `PCS_RESP_SLVERR;
         endcase
      end
      if (rvalid && rready)
         next_rvalid = 1'b0;
      if (arvalid && arready)
      begin
         next_rvalid  = 1'b1;
         next_rresp   = `PCS_RESP_OKAY;
         next_rd_trim = (araddr == `PCS_OFS_TRIM);
         case (araddr)
            `PCS_OFS_TRIM:
               next_rdata = {24'h000000, trim & `PCS_TRIM_MASK};          // RULE1
            `PCS_OFS_STATUS:
               next_rdata = {26'h0000000, page_select_bit, 5'h00};
            `PCS_OFS_PC:
               next_rdata = {22'h000000, instr_pointer};                 // RULE5 asks for bits 7:0, this reads counter bits 9:0
            `PCS_OFS_ACC:
               next_rdata = {24'h000000, acc};
            default:
            begin
               next_rdata = 32'h00000000;
               next_rresp = `PCS_RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trim            <= `PCS_TRIM_RESET;
         page_select_bit <= 1'b0;                    // RULE11
         aw_held         <= 1'b0;
         aw_addr_q       <= 8'h00;
         w_held          <= 1'b0;
         w_data_q        <= 8'h00;
         w_strb_q        <= 1'b0;
         bvalid          <= 1'b0;
         bresp           <= `PCS_RESP_OKAY;
         rvalid          <= 1'b0;
         rdata           <= 32'h00000000;
         rresp           <= `PCS_RESP_OKAY;
         rd_trim         <= 1'b0;
      end
      else
      begin
         trim            <= next_trim;
         page_select_bit <= next_page;
         aw_held         <= next_aw_held;
         aw_addr_q       <= next_aw_addr;
         w_held          <= next_w_held;
         w_data_q        <= next_w_data;
         w_strb_q        <= next_w_strb;
         bvalid          <= next_bvalid;
         bresp           <= next_bresp;
         rvalid          <= next_rvalid;
         rdata           <= next_rdata;
         rresp           <= next_rresp;
         rd_trim         <= next_rd_trim;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_trim_lsb;
      $rose(rvalid) && rd_trim |-> rdata[0] == 1'b0 && rdata[7:1] == $past(trim[7:1]);
   endproperty
   a_trim_lsb: assert property (p_trim_lsb) else $error("trim bit0 not zero"); // RULE1

   property p_max_freq;
      trim[7:1] == 7'h3F |-> osc_speed == 7'h7F;
   endproperty
   a_max_freq: assert property (p_max_freq) else $error("trim max not fastest"); // RULE2

   property p_advance;
      cycle_tick && op == PCS_OP_SEQ |=> instr_pointer == 10'($past(instr_pointer) + 10'h001);
   endproperty
   a_advance: assert property (p_advance) else $error("counter did not advance"); // RULE3

   property p_hold;
      !cycle_tick |=> $stable(instr_pointer);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved off cycle"); // RULE3

   property p_jump;
      cycle_tick && op == PCS_OP_JUMP |=> instr_pointer == {$past(page_select_bit), $past(operand)};
   endproperty
   a_jump: assert property (p_jump) else $error("jump target wrong"); // RULE4

   property p_low_load;
      cycle_tick && (op == PCS_OP_CALL || op == PCS_OP_PCL_WRITE)
         |=> instr_pointer == {$past(page_select_bit), 1'b0, $past(operand[7:0])};
   endproperty
   a_low_load: assert property (p_low_load) else $error("bit8 not cleared"); // RULE7

   property p_reset_vector;
      $rose(aresetn) |-> instr_pointer == 10'h3FF && !page_select_bit;
   endproperty
   a_reset_vector: assert property (p_reset_vector) else $error("bad reset state"); // RULE9

   property p_wrap;
      cycle_tick && op == PCS_OP_LOAD_LIT && instr_pointer == 10'h3FF
         |=> instr_pointer == 10'h000 && acc == $past(operand[7:0]);
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap to zero"); // RULE10

   property p_return;
      cycle_tick && op == PCS_OP_RET |=> instr_pointer == $past(stk.top[9:0]) && acc == $past(operand[7:0]);
   endproperty
   a_return: assert property (p_return) else $error("return load wrong"); // RULE16

   property p_call_ret;
      cycle_tick && op == PCS_OP_CALL
         |=> stk.top == {2'h0, 10'($past(instr_pointer) + 10'h001)};
   endproperty
   a_call_ret: assert property (p_call_ret) else $error("pushed address wrong"); // RULE13

endmodule

// >>> core/pcs_stack.sv
// Purpose: two-level return-address store
// Assumes: push and pop never both high
// Notes:   no overflow or underflow indication exists
`timescale 1ns/1ps
module pcs_stack #(
   parameter int WIDTH = 12
) (
   // clock and reset
   input  wire logic  aclk,
   input  wire logic  aresetn,
   // store side
   pcs_stack_if.store stk
);

   logic [WIDTH-1:0] level1;
   logic [WIDTH-1:0] level2;
   logic [WIDTH-1:0] next_level1;
   logic [WIDTH-1:0] next_level2;
   // last pushed word, and whether no pop has come since it
   logic [WIDTH-1:0] last_push;
   logic [WIDTH-1:0] next_last_push;
   logic             push_run;
   logic             next_push_run;

   if (WIDTH < 10)
   begin : g_chk
      $error("pcs_stack: WIDTH must hold a 10-bit address");
   end

   ////////////////////////////////////////////////////////////////////////
   // overflow drops the oldest address silently, no flag is kept
   always_comb
   begin
      next_level1    = level1;
      next_level2    = level2;
      next_last_push = last_push;
      next_push_run  = push_run;
      if (stk.push)
      begin
         next_level2    = level1;              // RULE14
         next_level1    = stk.push_data;       // RULE13
         next_last_push = stk.push_data;
         next_push_run  = 1'b1;
      end
      else if (stk.pop)
      begin
         next_level1   = level2;               // RULE15
         next_push_run = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         level1    <= '0;
         level2    <= '0;
         last_push <= '0;
         push_run  <= 1'b0;
      end
      else
      begin
         level1 <= next_level1;                // RULE12
         level2 <= next_level2;                // RULE17
         last_push <= next_last_push;
         push_run  <= next_push_run;
      end
   end

   assign stk.top = level1;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_push;
      stk.push |=> level1 == $past(stk.push_data) && level2 == $past(level1);
   endproperty
   a_push: assert property (p_push) else $error("push order wrong"); // RULE13

   property p_pop;
      stk.pop && !stk.push |=> level1 == $past(level2) && level2 == $past(level2);
   endproperty
   a_pop: assert property (p_pop) else $error("pop did not reuse level 2"); // RULE15

   // pushes come a whole instruction cycle apart, so the run is kept in helper state
   property p_three_calls;
      stk.push && push_run |=> level2 == $past(last_push) && level1 == $past(stk.push_data);
   endproperty
   a_three_calls: assert property (p_three_calls) else $error("oldest not dropped"); // RULE14

endmodule

// >>> shared/pcs_map.svh
// Purpose: register offsets, reset values and counts of the sequencing block
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   definitions only
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

`define PCS_OFS_TRIM     8'h00
`define PCS_OFS_STATUS   8'h04
`define PCS_OFS_PC       8'h08
`define PCS_OFS_ACC      8'h0C

`define PCS_TRIM_RESET   8'hFE
`define PCS_TRIM_MASK    8'hFE
`define PCS_PC_RESET     10'h3FF
`define PCS_PAGE_POS     5
`define PCS_CYCLE_DIV    4

`define PCS_RESP_OKAY    2'h0
`define PCS_RESP_SLVERR  2'h2

`endif

// >>> shared/pcs_pkg.sv
// Purpose: types shared by the sequencing block
// Assumes: nothing
// Notes:   operation codes are chosen by the enum, no fixed encoding
package pcs_pkg;

   typedef enum logic [2:0] {
      PCS_OP_SEQ,
      PCS_OP_LOAD_LIT,
      PCS_OP_JUMP,
      PCS_OP_CALL,
      PCS_OP_RET,
      PCS_OP_PCL_WRITE
   } pcs_op_type;

endpackage

// >>> shared/pcs_stack_if.sv
// Purpose: carrier between the sequencer and its return-address store
// Assumes: single clock domain
// Notes:   push and pop are one-cycle strobes
`timescale 1ns/1ps
interface pcs_stack_if #(parameter int WIDTH = 12);
   logic             push;
   logic             pop;
   logic [WIDTH-1:0] push_data;
   logic [WIDTH-1:0] top;

   modport owner (output push, output pop, output push_data, input top);
   modport store (input push, input pop, input push_data, output top);
endinterface

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the instruction sequencing block
// Assumes: four clocks per instruction cycle, ops held across one full cycle
// Notes:   a reference model follows pointer, stack and acc at every edge
`timescale 1ns/1ps
`include "pcs_map.svh"
module testbench
   import pcs_pkg::*;
;
   localparam int DIV = 4;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, cycle_tick, page_select_bit;
   logic [7:0]  awaddr, araddr, acc;
   logic [2:0]  awprot, arprot;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   pcs_op_type  op;
   logic [8:0]  operand;
   logic [9:0]  instr_pointer, e_ip;
   logic [6:0]  osc_trim_code, osc_speed;
   logic [7:0]  e_acc, e_trim;
   logic [11:0] e_s1, e_s2;
   logic        e_page;
   int          cnt, n_errors, num_checks, k;
   bit          started;

   pcs_core #(.CYCLE_DIV(DIV)) u_dut (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .cycle_tick(cycle_tick), .op(op), .operand(operand),
      .instr_pointer(instr_pointer), .acc(acc), .page_select_bit(page_select_bit),
      .osc_trim_code(osc_trim_code), .osc_speed(osc_speed));

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // reference model; reads op through the same edge the design samples it on
   always @(posedge aclk)
   begin
      started = 1'b1;
      if (!aresetn)
      begin
         e_ip   = `PCS_PC_RESET;
         e_acc  = 8'h00;
         e_s1   = 12'h000;
         e_s2   = 12'h000;
         e_page = 1'b0;
         e_trim = `PCS_TRIM_RESET;
         cnt    = 0;
      end
      else
      begin
         if (cnt == DIV - 1)
         begin
            case (op)
               PCS_OP_JUMP:      e_ip = {e_page, operand};
               PCS_OP_PCL_WRITE: e_ip = {e_page, 1'b0, operand[7:0]};
               PCS_OP_CALL:
               begin
                  e_s2 = e_s1;
                  e_s1 = {2'h0, e_ip + 10'h001};
                  e_ip = {e_page, 1'b0, operand[7:0]};
               end
               PCS_OP_RET:
               begin
                  e_ip  = e_s1[9:0];
                  e_s1  = e_s2;
                  e_acc = operand[7:0];
               end
               PCS_OP_LOAD_LIT:
               begin
                  e_acc = operand[7:0];
                  e_ip  = e_ip + 10'h001;
               end
               default:          e_ip = e_ip + 10'h001;
            endcase
         end
         cnt = (cnt == DIV - 1) ? 0 : cnt + 1;
      end
   end

   always @(negedge aclk)
      if (started)
      begin
         chk(instr_pointer, e_ip);
         chk(acc, e_acc);
         chk(cycle_tick, cnt == DIV - 1);
      end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      if (n_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   function automatic logic [1:0] resp_of(input logic [7:0] a);
      return (a[1:0] == 2'h0 && a <= `PCS_OFS_ACC) ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
   endfunction

   function automatic logic [31:0] rd_of(input logic [7:0] a);
      case (a)
         `PCS_OFS_TRIM:   return {24'h000000, e_trim};
         `PCS_OFS_STATUS: return {26'h0000000, e_page, 5'h00};
         `PCS_OFS_PC:     return {22'h000000, e_ip};
         `PCS_OFS_ACC:    return {24'h000000, e_acc};
         default:         return 32'h00000000;
      endcase
   endfunction

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int   i;
      logic got;
      got = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 100 && !got; i++)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            got = 1'b1;
            bready <= 1'b0;
            chk(bresp, resp_of(a));
         end
      end
      // unmapped, read-only or strobe-less writes leave the model untouched
      if (resp_of(a) === `PCS_RESP_OKAY && s[0] && a == `PCS_OFS_TRIM) e_trim = d[7:0] & `PCS_TRIM_MASK;
      if (resp_of(a) === `PCS_RESP_OKAY && s[0] && a == `PCS_OFS_STATUS) e_page = d[`PCS_PAGE_POS];
      chk(osc_trim_code, e_trim[7:1]);
      chk(osc_speed, 7'(e_trim[7:1] + 7'h40));
      chk(page_select_bit, e_page);
      if (!got)
      begin
         n_errors++;
         tally_and_finish();
      end
   endtask

   task automatic axr(input logic [7:0] a);
      int          i;
      logic        got;
      logic [31:0] exp_rd;
      got    = 1'b0;
      exp_rd = 32'h00000000;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 100 && !got; i++)
      begin
         // snapshot the model before the edge that takes the address
         @(negedge aclk);
         if (arvalid && arready) exp_rd = rd_of(a);
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            got = 1'b1;
            rready <= 1'b0;
            chk(rresp, resp_of(a));
            chk(rdata, exp_rd);
         end
      end
      if (!got)
      begin
         n_errors++;
         tally_and_finish();
      end
   endtask

   // one op spans a whole instruction cycle so exactly one tick samples it
   task automatic op_run(input pcs_op_type o, input logic [8:0] d);
      op      <= o;
      operand <= d;
      repeat (DIV) @(posedge aclk);
      op <= PCS_OP_SEQ;
      @(posedge aclk);
   endtask

   task automatic do_reset;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb, awprot, arprot} = 58'h0;
      op         = PCS_OP_SEQ;
      operand    = 9'h000;
      n_errors   = 0;
      num_checks = 0;
      void'($urandom(15));
      do_reset();
      op_run(PCS_OP_LOAD_LIT, 9'h05A);
      chk(acc, 8'h5A);
      axr(`PCS_OFS_TRIM);
      axr(`PCS_OFS_STATUS);
      axr(`PCS_OFS_ACC);
      axw(`PCS_OFS_TRIM, 32'h000000FF, 4'hF);
      axr(`PCS_OFS_TRIM);
      axw(`PCS_OFS_TRIM, 32'h0000007E, 4'hF);
      axw(`PCS_OFS_TRIM, 32'h00000080, 4'h0);
      axw(`PCS_OFS_PC, 32'h00000055, 4'hF);
      axw(8'h10, 32'h00000011, 4'hF);
      axr(8'h10);
      axw(`PCS_OFS_STATUS, 32'h00000020, 4'hF);
      axr(`PCS_OFS_STATUS);
      op_run(PCS_OP_JUMP, 9'h1AB);
      op_run(PCS_OP_CALL, 9'h110);
      op_run(PCS_OP_CALL, 9'h020);
      op_run(PCS_OP_CALL, 9'h130);
      for (k = 0; k < 3; k++)
         op_run(PCS_OP_RET, 9'(8'h33 + k));
      op_run(PCS_OP_PCL_WRITE, 9'h1FF);
      axr(`PCS_OFS_PC);
      axr(`PCS_OFS_ACC);
      for (k = 0; k < 80; k++)
         if (k % 9 == 4)
            axw(`PCS_OFS_STATUS, $urandom, 4'hF);
         else
            op_run(pcs_op_type'($urandom % 6), 9'($urandom));
      axw(`PCS_OFS_STATUS, 32'h00000020, 4'hF);
      @(posedge aclk);
      do_reset();
      @(posedge aclk);
      chk(page_select_bit, 1'b0);
      axr(`PCS_OFS_STATUS);
      op_run(PCS_OP_JUMP, 9'h0C3);
      tally_and_finish();
   end
endmodule
